// File: src/bit_clear_and_flag_branch_exec.sv
// Execute unit for single-bit clear and the flag-conditioned relative branches.
// Assumes the core supplies a stable instruction word and flags for each instruction cycle,
// and that one instruction cycle is four clocks (Q1..Q4) counted here.
`default_nettype none
module bit_clear_and_flag_branch_exec
  import bcb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_instr,
  input wire status_t i_status,
  input wire logic [3:0] i_bank_select_reg,
  input wire logic [ADDR_W-1:0] i_index_base,
  input wire logic i_ext_set_en,
  output logic [PC_W-1:0] o_program_counter,
  output logic o_instr_done,
  output logic o_nop_cycle,
  output ram_wr_t o_ram_wr,
  output status_t o_status
);
  typedef enum {S_EXEC, S_FLUSH} state_t;

  state_t state, next_state;
  logic [1:0] q_phase, next_q_phase;
  logic [PC_W-1:0] program_counter, next_program_counter;
  ram_wr_t ram_wr, next_ram_wr;
  logic [ADDR_W-1:0] rd_addr, next_rd_addr;
  logic [7:0] rd_data;
  logic is_clear, is_branch, cond_true, take;
  logic [PC_W-1:0] target;

  bcb_ram #(.AW(ADDR_W)) u_ram (
    .i_ref_clk(i_ref_clk),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data),
    .i_wr_en(ram_wr.en),
    .i_wr_addr(ram_wr.addr),
    .i_wr_data(ram_wr.data)
  );

  // Decode and branch condition
  always_comb begin
    is_clear = (i_instr[15:12] == OP_BIT_CLEAR);
    is_branch = 1'b1;
    cond_true = 1'b0;
    // Bit-clear opcodes land in the default arm, so they never count as branches
    unique case (i_instr[15:8])
      OP_BR_NEG: cond_true = i_status.neg;
      OP_BR_NO_CARRY: cond_true = !i_status.carry;
      OP_BR_NOT_NEG: cond_true = !i_status.neg;
      OP_BR_NO_OVF: cond_true = !i_status.ovf;
      OP_BR_NONZERO: cond_true = !i_status.zero;
      default: is_branch = 1'b0;
    endcase
    take = is_branch && cond_true;
    // sign-extended word offset added to incremented address
    target = program_counter + PC_STEP
      + PC_W'({{(PC_W-9){i_instr[7]}}, i_instr[7:0], 1'b0});
  end

  // Sequencing across Q phases; a taken branch adds one flush cycle
  always_comb begin
    next_state = state;
    next_q_phase = q_phase + 2'h1;
    next_program_counter = program_counter;
    next_ram_wr = '0;
    next_rd_addr = rd_addr;
    if (state == S_EXEC) begin
      // address forming for bit-clear, read in Q2
      if (q_phase == 2'h0 && is_clear) begin
        if (i_instr[8]) begin
          next_rd_addr = {i_bank_select_reg, i_instr[7:0]};
        end else if (i_ext_set_en && i_instr[7:0] <= LIT_OFS_LIMIT) begin
          next_rd_addr = i_index_base + ADDR_W'(i_instr[7:0]);
        end else if (i_instr[7:0] >= ACCESS_SPLIT) begin
          next_rd_addr = {ACCESS_HI_BANK, i_instr[7:0]};
        end else begin
          next_rd_addr = {4'h0, i_instr[7:0]};
        end
      end
      // modify in Q3 and write back in Q4
      if (q_phase == Q_LAST - 2'h1 && is_clear) begin
        next_ram_wr.en = 1'b1;
        next_ram_wr.addr = rd_addr;
        next_ram_wr.data = rd_data & ~(8'h01 << i_instr[11:9]);
      end
      if (q_phase == Q_LAST) begin
        // not taken: one cycle; taken: load target then flush
        if (take) begin
          next_program_counter = target;
          next_state = S_FLUSH;
        end else begin
          next_program_counter = program_counter + PC_STEP;
        end
      end
    end else if (q_phase == Q_LAST) begin
      next_state = S_EXEC;
    end
  end

  // State registers
  // Reset leaves the unit at Q1 of a fresh cycle with no write pending
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_EXEC;
      q_phase <= 2'h0;
      program_counter <= '0;
      ram_wr <= '0;
      rd_addr <= '0;
    end else begin
      state <= next_state;
      q_phase <= next_q_phase;
      program_counter <= next_program_counter;
      ram_wr <= next_ram_wr;
      rd_addr <= next_rd_addr;
    end
  end

  // Done is held off in Q4 of a taken branch; the flush cycle's Q4 completes it
  assign o_program_counter = program_counter;
  assign o_ram_wr = ram_wr;
  assign o_instr_done = (q_phase == Q_LAST) && !(state == S_EXEC && take);
  assign o_nop_cycle = (state == S_FLUSH);
  assign o_status = i_status;

  // Branch checks look at the state that follows, so a broken decode or sequencer shows up
  // flush follows taken
  a_taken_flush: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == Q_LAST && take) |=> (state == S_FLUSH)[*4] ##1 (state == S_EXEC))
    else $error("taken branch flush wrong");
  a_target_load: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == Q_LAST && take) |=> program_counter == $past(target))
    else $error("branch target wrong");
  a_fall_through: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == Q_LAST && !take) |=> program_counter == $past(program_counter) + PC_STEP)
    else $error("fall through wrong");
  a_neg_branch: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == Q_LAST && i_instr[15:8] == OP_BR_NEG)
    |=> (state == S_FLUSH) == $past(i_status.neg))
    else $error("negative branch cond");
  a_carry_branch: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == Q_LAST && i_instr[15:8] == OP_BR_NO_CARRY)
    |=> (state == S_FLUSH) == !$past(i_status.carry))
    else $error("carry branch cond");
  a_nneg_branch: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == Q_LAST && i_instr[15:8] == OP_BR_NOT_NEG)
    |=> (state == S_FLUSH) == !$past(i_status.neg))
    else $error("not neg branch cond");
  a_ovf_branch: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == Q_LAST && i_instr[15:8] == OP_BR_NO_OVF)
    |=> (state == S_FLUSH) == !$past(i_status.ovf))
    else $error("overflow branch cond");
  a_zero_branch: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == Q_LAST && i_instr[15:8] == OP_BR_NONZERO)
    |=> (state == S_FLUSH) == !$past(i_status.zero))
    else $error("zero branch cond");
  a_flush_end: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_FLUSH && q_phase == Q_LAST) |=> (state == S_EXEC && q_phase == 2'h0))
    else $error("flush cycle did not end");
  a_flush_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_FLUSH) |-> !ram_wr.en)
    else $error("write during flush cycle");
  // counter moves only at cycle end
  a_pc_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (q_phase != Q_LAST) |=> $stable(program_counter))
    else $error("program counter moved mid cycle");
  a_bank_addr: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == 2'h1 && is_clear && i_instr[8])
    |-> rd_addr == {i_bank_select_reg, i_instr[7:0]})
    else $error("banked clear address wrong");
  a_index_addr: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == 2'h1 && is_clear && !i_instr[8]
      && i_ext_set_en && i_instr[7:0] <= LIT_OFS_LIMIT)
    |-> rd_addr == i_index_base + ADDR_W'(i_instr[7:0]))
    else $error("indexed clear address wrong");
  a_access_addr: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == S_EXEC && q_phase == 2'h1 && is_clear && !i_instr[8]
      && !(i_ext_set_en && i_instr[7:0] <= LIT_OFS_LIMIT))
    |-> rd_addr == {(i_instr[7:0] >= ACCESS_SPLIT) ? ACCESS_HI_BANK : 4'h0, i_instr[7:0]})
    else $error("access bank clear address wrong");
  a_clear_bit: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ram_wr.en |-> ram_wr.data[$past(i_instr[11:9])] == 1'b0) else $error("bit not cleared");
  a_clear_timing: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ram_wr.en |-> q_phase == Q_LAST) else $error("clear write not in last phase");
  a_write_once: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ram_wr.en |=> !ram_wr.en) else $error("clear write held too long");
endmodule
`default_nettype wire

// File: src/bcb_pkg.sv
// Package for the bit-clear and flag-branch execute block.
// Assumes an 8-bit data path, 16-bit instruction words and byte-addressed program memory.
package bcb_pkg;
  localparam int unsigned PC_W = 21;
  localparam int unsigned ADDR_W = 12;
  // Opcode fields
  localparam logic [3:0] OP_BIT_CLEAR = 4'h9;
  localparam logic [7:0] OP_BR_NONZERO = 8'he1;
  localparam logic [7:0] OP_BR_NO_CARRY = 8'he3;
  localparam logic [7:0] OP_BR_NO_OVF = 8'he5;
  localparam logic [7:0] OP_BR_NEG = 8'he6;
  localparam logic [7:0] OP_BR_NOT_NEG = 8'he7;
  // Literal offset window limit and access bank split
  localparam logic [7:0] LIT_OFS_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [1:0] Q_LAST = 2'h3;
  // Status flags from the core
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic carry;
  } status_t;
  // One data-memory write
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } ram_wr_t;
endpackage

// File: src/bcb_ram.sv
// Small general purpose data memory with a registered read port.
// Assumes one write port and one read port on the same clock.
`default_nettype none
module bcb_ram
  import bcb_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Read first in array, read data always registered
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule
`default_nettype wire

// File: testbench/bit_clear_and_flag_branch_exec_tb.sv
// Self-checking bench for the bit-clear and flag-branch execute unit.
// Assumes bcb_pkg and the design are compiled first; the bench drives every port itself.
`default_nettype none
module bit_clear_and_flag_branch_exec_tb import bcb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] ins; status_t st; logic tk;} row_t;
  logic i_ref_clk, i_resetn, i_ext_set_en, o_instr_done, o_nop_cycle, cur_ext;
  logic [15:0] i_instr;
  status_t i_status, o_status;
  logic [3:0] i_bank_select_reg, cur_bsr;
  logic [ADDR_W-1:0] i_index_base, cur_base;
  logic [PC_W-1:0] o_program_counter, exp_pc;
  ram_wr_t o_ram_wr, wr;
  int err_total, compares;
  // Clear opcodes: three for the plain bank paths, three with the extended set on: both sides of the window edge and one banked
  logic [15:0] clr_ops [6] = '{16'h9070, 16'h9e20, 16'h9344, 16'h905f, 16'h9060, 16'h9110};
  // Branch rows: opcode and offset, flags, expected taken; offsets hit both ends of the range
  row_t rows [11] = '{
    '{{OP_BR_NEG, 8'h7f}, 4'b1000, 1'b1}, '{{OP_BR_NOT_NEG, 8'h80}, 4'b0111, 1'b1},
    '{{OP_BR_NEG, 8'h05}, 4'b0111, 1'b0}, '{{OP_BR_NOT_NEG, 8'h10}, 4'b1000, 1'b0},
    '{{OP_BR_NO_CARRY, 8'hff}, 4'b1110, 1'b1}, '{{OP_BR_NO_CARRY, 8'h01}, 4'b0001, 1'b0},
    '{{OP_BR_NO_OVF, 8'h00}, 4'b1011, 1'b1}, '{{OP_BR_NO_OVF, 8'h02}, 4'b0100, 1'b0},
    '{{OP_BR_NONZERO, 8'h80}, 4'b1101, 1'b1}, '{{OP_BR_NONZERO, 8'h03}, 4'b0010, 1'b0},
    '{16'h0000, 4'b0000, 1'b0}};
  bit_clear_and_flag_branch_exec dut_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_instr(i_instr),
    .i_status(i_status), .i_bank_select_reg(i_bank_select_reg), .i_index_base(i_index_base),
    .i_ext_set_en(i_ext_set_en), .o_program_counter(o_program_counter), .o_instr_done(o_instr_done),
    .o_nop_cycle(o_nop_cycle), .o_ram_wr(o_ram_wr), .o_status(o_status));
  // Free-running 100 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Expected clear address, worked out from the bench's own copy of the bank settings
  function automatic logic [ADDR_W-1:0] clr_addr(input logic [15:0] ins);
    if (ins[8]) return {cur_bsr, ins[7:0]};
    if (cur_ext && ins[7:0] <= LIT_OFS_LIMIT) return cur_base + {4'h0, ins[7:0]};
    if (ins[7:0] < ACCESS_SPLIT) return {4'h0, ins[7:0]};
    return {ACCESS_HI_BANK, ins[7:0]};
  endfunction
  // Entered at the edge that ends a cycle; the expected length decides how long to watch
  task automatic exec(input logic [15:0] ins, input status_t st, input logic tk, output ram_wr_t w);
    int nwr, nnop;
    nwr = 0;
    nnop = 0;
    w = '0;
    i_instr <= ins;
    i_status <= st;
    for (int i = 0; i < (tk ? 8 : 4); i++) begin
      @(negedge i_ref_clk);
      if (i == 0) check("pc", exp_pc, o_program_counter);
      if (o_ram_wr.en === 1'b1) begin
        nwr++;
        w = o_ram_wr;
      end
      if (o_nop_cycle === 1'b1) nnop++;
      // A taken branch completes only in the Q4 of its flush cycle
      check("done", (i == (tk ? 7 : 3)), o_instr_done);
      check("flags", st, o_status);
      @(posedge i_ref_clk);
    end
    // Target counts bytes: next word plus twice the sign-extended offset
    exp_pc = exp_pc + PC_STEP + (tk ? {{12{ins[7]}}, ins[7:0], 1'b0} : '0);
    check("nop clocks", tk ? 4 : 0, nnop);
    check("writes", ins[15:12] == OP_BIT_CLEAR, nwr);
    if (nwr > 0) check("wr addr", clr_addr(ins), w.addr);
    if (nwr > 0) check("bit cleared", 0, w.data[ins[11:9]]);
  endtask
  task automatic do_reset(input int n);
    i_resetn <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check("reset pc", 0, o_program_counter);
    check("reset wr", 0, o_ram_wr.en);
    check("reset nop", 0, o_nop_cycle);
    @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    exp_pc = '0;
  endtask
  // Settings change at a cycle edge, then one unknown opcode lets them settle
  task automatic cfg(input logic [3:0] b, input logic e, input logic [ADDR_W-1:0] base);
    {cur_bsr, cur_ext, cur_base} = {b, e, base};
    {i_bank_select_reg, i_ext_set_en, i_index_base} <= {b, e, base};
    exec(16'h0000, 4'b0000, 1'b0, wr);
  endtask
  // Hang guard sized well past the expected run of about 170 clocks
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    err_total++;
    print_verdict();
  end
  initial begin
    {i_resetn, i_instr, i_status, i_bank_select_reg, i_index_base, i_ext_set_en} = '0;
    {cur_bsr, cur_ext, cur_base, exp_pc} = '0;
    do_reset(20);
    foreach (rows[i]) exec(rows[i].ins, rows[i].st, rows[i].tk, wr);
    $display("Test branch table done");
    cfg(4'h3, 1'b0, 12'h000);
    for (int i = 0; i < 3; i++) exec(clr_ops[i], 4'hf, 1'b0, wr);
    cfg(4'h3, 1'b1, 12'h200);
    // Indexed window edge at 5Fh, plain access bank just past it
    for (int i = 3; i < 6; i++) exec(clr_ops[i], 4'hf, 1'b0, wr);
    $display("Test clear addressing done");
    // Clearing every bit of one byte in turn must leave it zero
    for (int k = 0; k < 9; k++) begin
      exec(16'h9110 | 16'((k % 8) << 9), 4'h5, 1'b0, wr);
      check("cleared so far", 0, wr.data & 8'((9'h2 << (k % 8)) - 1));
    end
    check("byte zero", 8'h00, wr.data);
    $display("Test bit clear sequence done");
    do_reset(2);
    exec(rows[0].ins, rows[0].st, rows[0].tk, wr);
    exec(16'h0000, 4'b0000, 1'b0, wr);
    $display("Test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
